// File: hdl/shared_param_memory_pkg.sv
// constants and types for the shared parameter memory access block
// Function
// - 32-bit memory, host byte/half/word access
// - engine moves full word, low 24, top byte
// - mirror region reads as sign-extended words
// - mirror writes keep the top byte
// - mirror reads copy bit 23 upward
// - lowest byte address is the top byte
// - channel base points to even parameters
// - relative mode: base plus 128-parameter offset
// - indirect mode reaches the whole memory
// - absolute mode reaches first 256 parameters
// - one parameter is four host bytes
// - engine access width may change every access
// - host and both engines share one memory
// - pair transfers staged through temporary area
// - lost arbitration adds engine wait states
// - engine code grant blocks host code access
package shared_param_memory_pkg;
  // ---------------------------------------------------------------
  // host access sizes and engine access widths
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] ESZ_FULL = 2'h0;
  localparam logic [1:0] ESZ_LOW24 = 2'h1;
  localparam logic [1:0] ESZ_TOP8 = 2'h2;
  // byte lane masks, bit 3 is the most significant lane
  localparam logic [3:0] MASK_FULL = 4'hf;
  localparam logic [3:0] MASK_LOW24 = 4'h7;
  localparam logic [3:0] MASK_TOP8 = 4'h8;
  localparam logic [3:0] MASK_HI16 = 4'hc;
  localparam logic [3:0] MASK_LO16 = 4'h3;
  // ---------------------------------------------------------------
  // engine addressing modes and reach
  // ---------------------------------------------------------------
  localparam logic [1:0] AM_REL = 2'h0;
  localparam logic [1:0] AM_IND = 2'h1;
  localparam logic [1:0] AM_ABS = 2'h2;
  localparam int REL_OFS_W = 7;
  localparam int ABS_OFS_W = 8;
  localparam int BYTES_PER_PARAM = 4;
  localparam int LANE_BITS = 2;
  localparam int SEXT_BIT = 23;
  // ---------------------------------------------------------------
  // timing: one engine microcycle is two system clocks
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int MICROCYCLE_NS = 200;
  localparam int MICRO_CLKS = MICROCYCLE_NS / CLK_NS;
  // pair transfer sequencer
  typedef enum logic [1:0] {COH_IDLE, COH_W0, COH_W1} shared_param_memory_coh_t;
endpackage

// File: hdl/shared_param_memory_access.sv
// shared parameter memory with host port, two engine ports and arbiter
`timescale 1ns/1ps
module shared_param_memory_access #(
  parameter int DEPTH = 2048,
  parameter int NENG = 2,
  parameter int NCHAN = 32,
  parameter int COH_TEMP = DEPTH - 2
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic host_req_i,
  input wire logic host_we_i,
  input wire logic [1:0] host_size_i,
  input wire logic [$clog2(DEPTH)+2:0] host_addr_i,
  input wire logic [31:0] host_wdata_i,
  output logic host_ack_o,
  output logic [31:0] host_rdata_o,
  input wire logic host_code_req_i,
  input wire logic scm_eng_grant_i,
  output logic host_code_ok_o,
  input wire logic base_we_i,
  input wire logic [$clog2(NENG)-1:0] base_eng_i,
  input wire logic [$clog2(NCHAN)-1:0] base_chan_i,
  input wire logic [$clog2(DEPTH)-2:0] base_pair_i,
  input wire logic coh_start_i,
  input wire logic coh_to_mem_i,
  input wire logic [$clog2(DEPTH)-2:0] coh_pair_i,
  output logic coh_busy_o,
  output logic coh_done_o,
  input wire logic [NENG-1:0] eng_req_i,
  input wire logic [NENG-1:0] eng_we_i,
  input wire logic [NENG-1:0][1:0] eng_mode_i,
  input wire logic [NENG-1:0][1:0] eng_size_i,
  input wire logic [NENG-1:0][$clog2(NCHAN)-1:0] eng_chan_i,
  input wire logic [NENG-1:0][$clog2(DEPTH)-1:0] eng_addr_i,
  input wire logic [NENG-1:0][31:0] eng_wdata_i,
  output logic [NENG-1:0] eng_ack_o,
  output logic [NENG-1:0] eng_wait_o,
  output logic [NENG-1:0][31:0] eng_rdata_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int NR = NENG + 1;
  localparam int LW = $clog2(NR);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // host lane mask; byte offset 0 is the most significant lane
  function automatic logic [3:0] host_mask(input logic [1:0] sz,
                                           input logic [1:0] off);
    logic [3:0] m;
    m = shared_param_memory_pkg::MASK_FULL;
    if (sz == shared_param_memory_pkg::SZ_BYTE) begin
      m = shared_param_memory_pkg::MASK_TOP8 >> off;
    end else if (sz == shared_param_memory_pkg::SZ_HALF) begin
      m = off[1] ? shared_param_memory_pkg::MASK_LO16 : shared_param_memory_pkg::MASK_HI16;
    end
    return m;
  endfunction

  // width per access
  // engine width to lane mask, no state so width may change freely
  function automatic logic [3:0] eng_mask(input logic [1:0] sz);
    logic [3:0] m;
    m = shared_param_memory_pkg::MASK_FULL;
    if (sz == shared_param_memory_pkg::ESZ_LOW24) begin
      m = shared_param_memory_pkg::MASK_LOW24;
    end else if (sz == shared_param_memory_pkg::ESZ_TOP8) begin
      m = shared_param_memory_pkg::MASK_TOP8;
    end
    return m;
  endfunction

  // merge or mask a word by lanes
  function automatic logic [31:0] lanes(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] m);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction

  // round robin: first requester after the last winner
  function automatic logic [NR-1:0] rr_pick(input logic [NR-1:0] r,
                                            input logic [LW-1:0] lp);
    logic [NR-1:0] g;
    int j;
    g = '0;
    for (int k = NR; k >= 1; k--) begin
      j = (int'(lp) + k) % NR;
      if (r[j]) begin
        g = NR'(1) << j;
      end
    end
    return g;
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [31:0] mem_q [DEPTH];
  logic [AW-2:0] base_q [NENG][NCHAN];
  logic [LW-1:0] last_q;
  logic host_ack_q;
  logic [31:0] host_rdata_q;
  logic [NENG-1:0] eng_ack_q;
  logic [NENG-1:0][31:0] eng_rdata_q;
  shared_param_memory_pkg::shared_param_memory_coh_t coh_q;
  logic coh_dir_q;
  logic [AW-2:0] coh_pair_q;
  logic coh_done_q;

  // ---------------------------------------------------------------
  // host decode
  // ---------------------------------------------------------------
  // mirror bit, four bytes per word
  wire host_mirror = host_addr_i[AW+2];
  wire [AW-1:0] host_idx = host_addr_i[AW+1:2];
  wire [1:0] host_off = host_addr_i[1:0];
  // big endian lanes; mirror writes never touch the top byte
  // lane order
  wire [3:0] host_m = host_mask(host_size_i, host_off) &
                      (host_mirror ? shared_param_memory_pkg::MASK_LOW24 :
                       shared_param_memory_pkg::MASK_FULL);

  // ---------------------------------------------------------------
  // engine address generation
  // ---------------------------------------------------------------
  logic [NENG-1:0][AW-1:0] eng_idx;
  always_comb begin
    for (int e = 0; e < NENG; e++) begin
      unique case (eng_mode_i[e])
        shared_param_memory_pkg::AM_REL: eng_idx[e] =
          {base_q[e][eng_chan_i[e]], 1'b0} +
          AW'(eng_addr_i[e][shared_param_memory_pkg::REL_OFS_W-1:0]);
        shared_param_memory_pkg::AM_ABS: eng_idx[e] =
          AW'(eng_addr_i[e][shared_param_memory_pkg::ABS_OFS_W-1:0]);
        default: eng_idx[e] = eng_addr_i[e];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  // a requester just acked is masked so one request is served once
  wire host_pend = host_req_i & ~host_ack_q;
  wire [NENG-1:0] eng_pend = eng_req_i & ~eng_ack_q;
  wire coh_act = (coh_q != shared_param_memory_pkg::COH_IDLE);
  wire [NR-1:0] gnt = coh_act ? '0 :
                      rr_pick({eng_pend, host_pend}, last_q);
  assign eng_wait_o = eng_pend & ~gnt[NR-1:1];

  // winner's access
  logic [AW-1:0] acc_idx;
  logic [3:0] acc_m;
  logic [31:0] acc_wd;
  logic acc_we;
  always_comb begin
    acc_idx = host_idx;
    acc_m = host_m;
    acc_wd = host_wdata_i;
    acc_we = gnt[0] & host_we_i;
    for (int e = 0; e < NENG; e++) begin
      if (gnt[e+1]) begin
        acc_idx = eng_idx[e];
        acc_m = eng_mask(eng_size_i[e]);
        acc_wd = eng_wdata_i[e];
        acc_we = eng_we_i[e];
      end
    end
  end
  wire [31:0] rd_word = mem_q[acc_idx];

  // ---------------------------------------------------------------
  // pair transfer through the temporary area
  // ---------------------------------------------------------------
  // two words move in back-to-back cycles with all others stalled,
  // so neither side ever sees half of a pair
  wire [AW-1:0] coh_k = AW'(coh_q == shared_param_memory_pkg::COH_W1);
  wire [AW-1:0] pair_w = {coh_pair_q, 1'b0} + coh_k;
  wire [AW-1:0] temp_w = AW'(COH_TEMP) + coh_k;
  wire [AW-1:0] coh_src = coh_dir_q ? temp_w : pair_w;
  wire [AW-1:0] coh_dst = coh_dir_q ? pair_w : temp_w;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      coh_q <= shared_param_memory_pkg::COH_IDLE;
      coh_dir_q <= 1'b0;
      coh_pair_q <= '0;
      coh_done_q <= 1'b0;
    end else begin
      coh_done_q <= (coh_q == shared_param_memory_pkg::COH_W1);
      unique case (coh_q)
        shared_param_memory_pkg::COH_IDLE: if (coh_start_i) begin
          coh_q <= shared_param_memory_pkg::COH_W0;
          coh_dir_q <= coh_to_mem_i;
          coh_pair_q <= coh_pair_i;
        end
        shared_param_memory_pkg::COH_W0: coh_q <= shared_param_memory_pkg::COH_W1;
        shared_param_memory_pkg::COH_W1: coh_q <= shared_param_memory_pkg::COH_IDLE;
      endcase
    end
  end
  assign coh_busy_o = coh_act;
  assign coh_done_o = coh_done_q;

  // ---------------------------------------------------------------
  // memory write port; contents are not reset
  // ---------------------------------------------------------------
  // lane writes
  always_ff @(posedge sys_clk_i) begin
    if (coh_act) begin
      mem_q[coh_dst] <= mem_q[coh_src];
    end else if (acc_we) begin
      mem_q[acc_idx] <= lanes(rd_word, acc_wd, acc_m);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      for (int e = 0; e < NENG; e++) begin
        for (int c = 0; c < NCHAN; c++) begin
          base_q[e][c] <= '0;
        end
      end
    end else if (base_we_i) begin
      base_q[base_eng_i][base_chan_i] <= base_pair_i;
    end
  end

  // ---------------------------------------------------------------
  // answers: ack one cycle after grant, so a won engine access
  // fills exactly one two-clock microcycle
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      last_q <= '0;
      host_ack_q <= 1'b0;
      eng_ack_q <= '0;
    end else begin
      host_ack_q <= gnt[0];
      eng_ack_q <= gnt[NR-1:1];
      for (int i = 0; i < NR; i++) begin
        if (gnt[i]) begin
          last_q <= LW'(i);
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      host_rdata_q <= '0;
      eng_rdata_q <= '0;
    end else begin
      if (gnt[0]) begin
        host_rdata_q <= host_mirror ?
          {{8{rd_word[shared_param_memory_pkg::SEXT_BIT]}}, rd_word[23:0]} : rd_word;
      end
      for (int e = 0; e < NENG; e++) begin
        if (gnt[e+1]) begin
          eng_rdata_q[e] <= lanes('0, rd_word, eng_mask(eng_size_i[e]));
        end
      end
    end
  end
  assign host_ack_o = host_ack_q;
  assign host_rdata_o = host_rdata_q;
  assign eng_ack_o = eng_ack_q;
  assign eng_rdata_o = eng_rdata_q;

  assign host_code_ok_o = host_code_req_i & ~scm_eng_grant_i;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic mir_wr_q;
  logic [AW-1:0] mir_idx_q;
  logic [7:0] mir_top_q;
  always_ff @(posedge sys_clk_i) begin
    mir_wr_q <= gnt[0] & host_we_i & host_mirror & ~srst_i;
    mir_idx_q <= host_idx;
    mir_top_q <= rd_word[31:24];
  end

  chk_one_grant: assert property ($onehot0(gnt))
    else $error("more than one grant in a cycle");
  chk_host_ack_next: assert property (gnt[0] |=> host_ack_o)
    else $error("host grant not answered next cycle");
  chk_mirror_top_kept: assert property (mir_wr_q |->
    mem_q[mir_idx_q][31:24] == mir_top_q)
    else $error("mirror write changed the top byte");
  chk_mirror_sext_read: assert property (gnt[0] && host_mirror |=>
    host_rdata_o[31:24] == {8{host_rdata_o[23]}})
    else $error("mirror read not sign extended");
  chk_eng_wait_lost: assert property (eng_pend[0] && !gnt[1] |->
    eng_wait_o[0] ##1 eng_req_i[0] |-> !eng_ack_o[0])
    else $error("lost engine access not stalled");
  chk_eng_microcycle: assert property (gnt[1] |=>
    eng_ack_o[0] ##1 !eng_ack_o[0] || gnt[1])
    else $error("engine access not one microcycle");
  chk_scm_lockout: assert property (scm_eng_grant_i |-> !host_code_ok_o)
    else $error("host code access while engines own it");
  chk_pair_atomic: assert property ($rose(coh_busy_o) |->
    gnt == '0 ##1 gnt == '0 ##1 !coh_busy_o ##0 coh_done_o)
    else $error("pair transfer interleaved");
  chk_top8_keeps_low: assert property (gnt[1] &&
    eng_size_i[0] == shared_param_memory_pkg::ESZ_TOP8 |=>
    eng_rdata_o[0][23:0] == 24'h000000)
    else $error("top byte read leaked low bits");
  chk_rel_even_base: assert property (eng_mode_i[0] ==
    shared_param_memory_pkg::AM_REL |-> eng_idx[0][0] == eng_addr_i[0][0])
    else $error("relative address on odd base");

  cov_mirror_write: cover property (mir_wr_q);
  cov_engine_waits: cover property (eng_wait_o[0] ##1 eng_ack_o[0]);
  cov_pair_to_mem: cover property (coh_start_i && coh_to_mem_i &&
    !coh_busy_o ##3 coh_done_o);
  cov_both_engines: cover property (&eng_pend);
endmodule

// File: verification/shared_param_memory_bus_model.sv
// requester model for the host port and both engine ports
`timescale 1ns/1ps
module shared_param_memory_bus_model (
  input wire logic clk_i,
  input wire logic host_ack_i,
  input wire logic [31:0] host_rdata_i,
  input wire logic [1:0] eng_ack_i,
  input wire logic [1:0][31:0] eng_rdata_i,
  output logic host_req_o,
  output logic host_we_o,
  output logic [1:0] host_size_o,
  output logic [13:0] host_addr_o,
  output logic [31:0] host_wdata_o,
  output logic [1:0] eng_req_o,
  output logic [1:0] eng_we_o,
  output logic [1:0][1:0] eng_mode_o,
  output logic [1:0][1:0] eng_size_o,
  output logic [1:0][4:0] eng_chan_o,
  output logic [1:0][10:0] eng_addr_o,
  output logic [1:0][31:0] eng_wdata_o
);
  // everything idle at time zero
  initial begin
    host_req_o = 1'b0;
    host_we_o = 1'b0;
    host_size_o = 2'h0;
    host_addr_o = '0;
    host_wdata_o = '0;
    eng_req_o = '0;
    eng_we_o = '0;
    eng_mode_o = '0;
    eng_size_o = '0;
    eng_chan_o = '0;
    eng_addr_o = '0;
    eng_wdata_o = '0;
  end
  // request held until ack, released one edge later; data then flips
  // so a stale bus value can never be mistaken for a fresh one
  task automatic host(input logic we, input logic [1:0] sz,
      input logic [13:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    #1;
    host_req_o = 1'b1;
    host_we_o = we;
    host_size_o = sz;
    host_addr_o = a;
    host_wdata_o = wd;
    n = 0;
    while (host_ack_i !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    rd = host_rdata_i;
    @(posedge clk_i);
    #1;
    host_req_o = 1'b0;
    host_wdata_o = ~wd;
  endtask
  // same handshake on one engine port
  task automatic eng(input int e, input logic we, input logic [1:0] m,
      input logic [1:0] sz, input logic [4:0] c, input logic [10:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    #1;
    eng_req_o[e] = 1'b1;
    eng_we_o[e] = we;
    eng_mode_o[e] = m;
    eng_size_o[e] = sz;
    eng_chan_o[e] = c;
    eng_addr_o[e] = a;
    eng_wdata_o[e] = wd;
    n = 0;
    while (eng_ack_i[e] !== 1'b1 && n < 64) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    rd = eng_rdata_i[e];
    @(posedge clk_i);
    #1;
    eng_req_o[e] = 1'b0;
    eng_wdata_o[e] = ~wd;
  endtask
endmodule

// File: verification/shared_param_memory_access_tb.sv
// self-checking bench for the shared parameter memory access block
`timescale 1ns/1ps
module shared_param_memory_access_tb;
  logic sys_clk_i, srst_i, host_req, host_we, host_ack;
  logic [1:0] host_size, eng_req, eng_we, eng_ack, eng_wait;
  logic [13:0] host_addr;
  logic [31:0] host_wdata, host_rdata, rd, erd;
  logic [1:0][1:0] eng_mode, eng_size;
  logic [1:0][4:0] eng_chan;
  logic [1:0][10:0] eng_addr;
  logic [1:0][31:0] eng_wdata, eng_rdata;
  logic code_req, code_grant, code_ok, base_we, base_eng;
  logic coh_start, coh_to_mem, coh_busy, coh_done, waits_seen;
  logic [4:0] base_chan;
  logic [9:0] base_pair, coh_pair;
  int miscompares, checks_done, cycles;
  shared_param_memory_access u_shared_param_memory_access (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .host_req_i(host_req), .host_we_i(host_we), .host_size_i(host_size),
    .host_addr_i(host_addr), .host_wdata_i(host_wdata),
    .host_ack_o(host_ack), .host_rdata_o(host_rdata),
    .host_code_req_i(code_req), .scm_eng_grant_i(code_grant),
    .host_code_ok_o(code_ok), .base_we_i(base_we), .base_eng_i(base_eng),
    .base_chan_i(base_chan), .base_pair_i(base_pair),
    .coh_start_i(coh_start), .coh_to_mem_i(coh_to_mem),
    .coh_pair_i(coh_pair), .coh_busy_o(coh_busy), .coh_done_o(coh_done),
    .eng_req_i(eng_req), .eng_we_i(eng_we), .eng_mode_i(eng_mode),
    .eng_size_i(eng_size), .eng_chan_i(eng_chan), .eng_addr_i(eng_addr),
    .eng_wdata_i(eng_wdata), .eng_ack_o(eng_ack), .eng_wait_o(eng_wait),
    .eng_rdata_o(eng_rdata));
  shared_param_memory_bus_model u_shared_param_memory_bus_model (.clk_i(sys_clk_i),
    .host_ack_i(host_ack), .host_rdata_i(host_rdata), .eng_ack_i(eng_ack),
    .eng_rdata_i(eng_rdata), .host_req_o(host_req), .host_we_o(host_we),
    .host_size_o(host_size), .host_addr_o(host_addr),
    .host_wdata_o(host_wdata), .eng_req_o(eng_req), .eng_we_o(eng_we),
    .eng_mode_o(eng_mode), .eng_size_o(eng_size), .eng_chan_o(eng_chan),
    .eng_addr_o(eng_addr), .eng_wdata_o(eng_wdata));
  // ---------------------------------------------------------------
  // clock, hang guard and shared helpers
  // ---------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // whole run needs about a hundred cycles; anything far beyond is a hang
  always @(posedge sys_clk_i) begin
    cycles++;
    if (|eng_wait) waits_seen = 1'b1;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hw(input logic [13:0] a, input logic [1:0] sz,
      input logic [31:0] wd);
    u_shared_param_memory_bus_model.host(1'b1, sz, a, wd, rd);
  endtask
  task automatic hr(input logic [13:0] a);
    u_shared_param_memory_bus_model.host(1'b0, shared_param_memory_pkg::SZ_WORD, a, 32'h0, rd);
  endtask
  task automatic en(input int e, input logic we, input logic [1:0] m,
      input logic [1:0] s, input logic [10:0] a, input logic [31:0] wd);
    u_shared_param_memory_bus_model.eng(e, we, m, s, 5'h03, a, wd, erd);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // lane writes of every size land big-endian in word 5
  task automatic t_host();
    hw(14'h0014, shared_param_memory_pkg::SZ_WORD, 32'h11223344);
    hw(14'h0015, shared_param_memory_pkg::SZ_BYTE, 32'h00aa0000);
    hw(14'h0016, shared_param_memory_pkg::SZ_HALF, 32'h0000beef);
    hw(14'h0014, shared_param_memory_pkg::SZ_BYTE, 32'h77000000);
    hr(14'h0014);
    chk(rd, 32'h77aabeef);
    $display("test host done");
  endtask
  // mirror keeps the top byte and copies bit 23 upward on reads
  task automatic t_mirror();
    hw(14'h2014, shared_param_memory_pkg::SZ_WORD, 32'h55800001);
    hr(14'h0014);
    chk(rd, 32'h77800001);
    hr(14'h2014);
    chk(rd, 32'hff800001);
    $display("test mirror done");
  endtask
  // base at pair 0x10, then widths switched on back-to-back accesses
  task automatic t_eng();
    @(posedge sys_clk_i);
    #1;
    base_we = 1'b1;
    @(posedge sys_clk_i);
    #1;
    base_we = 1'b0;
    hw(14'h0094, shared_param_memory_pkg::SZ_WORD, 32'ha1b2c3d4);
    en(0, 1'b0, shared_param_memory_pkg::AM_REL, shared_param_memory_pkg::ESZ_FULL, 11'h005, 0);
    chk(erd, 32'ha1b2c3d4);
    en(0, 1'b0, shared_param_memory_pkg::AM_REL, shared_param_memory_pkg::ESZ_LOW24, 11'h005, 0);
    chk(erd, 32'h00b2c3d4);
    en(0, 1'b0, shared_param_memory_pkg::AM_REL, shared_param_memory_pkg::ESZ_TOP8, 11'h005, 0);
    chk(erd, 32'ha1000000);
    en(1, 1'b1, shared_param_memory_pkg::AM_IND, shared_param_memory_pkg::ESZ_FULL, 11'h7f0, 32'hdead);
    en(0, 1'b0, shared_param_memory_pkg::AM_IND, shared_param_memory_pkg::ESZ_FULL, 11'h7f0, 0);
    chk(erd, 32'h0000dead);
    hw(14'h03fc, shared_param_memory_pkg::SZ_WORD, 32'h01020304);
    en(1, 1'b1, shared_param_memory_pkg::AM_ABS, shared_param_memory_pkg::ESZ_TOP8, 11'h7ff, 32'h5a << 24);
    hr(14'h03fc);
    chk(rd, 32'h5a020304);
    $display("test engine done");
  endtask
  // three requesters at once: someone waits, nothing is lost
  task automatic t_arb();
    waits_seen = 1'b0;
    fork
      hw(14'h00c0, shared_param_memory_pkg::SZ_WORD, 32'h0000c0c0);
      en(0, 1'b1, shared_param_memory_pkg::AM_IND, shared_param_memory_pkg::ESZ_FULL, 11'h031, 32'h31);
      en(1, 1'b1, shared_param_memory_pkg::AM_IND, shared_param_memory_pkg::ESZ_FULL, 11'h032, 32'h32);
    join
    chk({31'h0, waits_seen}, 32'h1);
    en(1, 1'b0, shared_param_memory_pkg::AM_IND, shared_param_memory_pkg::ESZ_FULL, 11'h030, 0);
    chk(erd, 32'h0000c0c0);
    hr(14'h00c4);
    chk(rd, 32'h31);
    hr(14'h00c8);
    chk(rd, 32'h32);
    $display("test arbitration done");
  endtask
  // pair 8 copied into the temporary pair at the top of memory
  task automatic t_coh();
    int n;
    hw(14'h0040, shared_param_memory_pkg::SZ_WORD, 32'h0a0a0a0a);
    hw(14'h0044, shared_param_memory_pkg::SZ_WORD, 32'h0b0b0b0b);
    @(posedge sys_clk_i);
    #1;
    coh_start = 1'b1;
    @(posedge sys_clk_i);
    #1;
    coh_start = 1'b0;
    chk({31'h0, coh_busy}, 32'h1);
    n = 0;
    while (coh_done !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk({31'h0, coh_done}, 32'h1);
    hr(14'h1ff8);
    chk(rd, 32'h0a0a0a0a);
    hr(14'h1ffc);
    chk(rd, 32'h0b0b0b0b);
    // reverse direction: temporary pair copied back into pair 8
    hw(14'h1ff8, shared_param_memory_pkg::SZ_WORD, 32'h0c0c0c0c);
    hw(14'h1ffc, shared_param_memory_pkg::SZ_WORD, 32'h0d0d0d0d);
    @(posedge sys_clk_i);
    #1;
    coh_to_mem = 1'b1;
    coh_start = 1'b1;
    @(posedge sys_clk_i);
    #1;
    coh_start = 1'b0;
    n = 0;
    while (coh_done !== 1'b1 && n < 8) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk({31'h0, coh_done}, 32'h1);
    hr(14'h0040);
    chk(rd, 32'h0c0c0c0c);
    hr(14'h0044);
    chk(rd, 32'h0d0d0d0d);
    $display("test coherency done");
  endtask
  // engine grant on code memory shuts the host out
  task automatic t_code();
    @(posedge sys_clk_i);
    #1;
    code_req = 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk({31'h0, code_ok}, 32'h1);
    code_grant = 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk({31'h0, code_ok}, 32'h0);
    $display("test code lockout done");
  endtask
  // main sequence; memory and bases are set before engines use them
  initial begin
    srst_i = 1'b1;
    code_req = 1'b0;
    code_grant = 1'b0;
    base_we = 1'b0;
    base_eng = 1'b0;
    base_chan = 5'h03;
    base_pair = 10'h010;
    coh_start = 1'b0;
    coh_to_mem = 1'b0;
    coh_pair = 10'h008;
    repeat (2) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    t_host();
    t_mirror();
    t_eng();
    t_arb();
    t_coh();
    t_code();
    finish_test();
  end
endmodule
